/* File: rtl/ppd_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Decode only 37E0, 37E4, 37E8 and 37EC
// - Address valid only while row strobe low
// - A11, A14, A15 low plus upper match
// - Selects strobe floppy and printer logic
// - Read selects: irq reset, none, status, floppy
// - Write selects: motor, cassette, printer, floppy
// - Eight bits out, four status bits in
// - Only upper status nibble is valid
// - Busy D7, paper D6, select D5, fault D4
// - Printer write loads output latch
// - Each printer write gives 1.5 us low strobe
// - Reading 37E0 clears floppy interrupt flag
module ppd_top
  import ppd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // CPU memory bus
  input wire logic [15:0] addr,
  input wire logic ras_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Printer pins
  output logic [7:0] prn_data,
  output logic prn_strobe_n,
  input wire logic prn_busy,
  input wire logic prn_paper_empty,
  input wire logic prn_selected,
  input wire logic prn_fault,
  // Floppy side
  input wire logic fdc_irq,
  output logic fdc_irq_flag,
  output logic fdc_rd_sel,
  output logic fdc_wr_sel,
  output logic motor_sel,
  output logic cassette_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all pins
  // Reset to the idle bus, so no false decode or request follows it
  logic [27:0] meta_ff;
  logic [27:0] sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= PPD_SYNC_IDLE;
      sync_ff <= PPD_SYNC_IDLE;
    end else begin
      meta_ff <= {addr, ras_n, rd_n, wr_n, data_in, fdc_irq};
      sync_ff <= meta_ff;
    end
  end

  wire logic [15:0] s_addr;
  wire logic s_ras_n;
  wire logic s_rd_n;
  wire logic s_wr_n;
  wire logic [7:0] s_data;
  wire logic s_irq;
  assign {s_addr, s_ras_n, s_rd_n, s_wr_n, s_data, s_irq} = sync_ff;

  // Status pins cross on their own; their idle level is low
  logic [3:0] st_meta_ff;
  logic [3:0] st_sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_meta_ff <= 4'h0;
      st_sync_ff <= 4'h0;
    end else begin
      st_meta_ff <= {prn_busy, prn_paper_empty, prn_selected, prn_fault};
      st_sync_ff <= st_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder sees only the synchronised copies of the bus
  ppd_sel_if sel ();
  ppd_decoder u_dec (
    .addr(s_addr),
    .ras_n(s_ras_n),
    .rd_n(s_rd_n),
    .wr_n(s_wr_n),
    .sel(sel)
  );

  // Edge detect: one action per bus cycle, not per clock of it
  // A held select would otherwise reload and restrobe every clock
  logic [3:0] rd_prev_ff;
  logic [3:0] wr_prev_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_prev_ff <= 4'h0;
      wr_prev_ff <= 4'h0;
    end else begin
      rd_prev_ff <= sel.rd_sel;
      wr_prev_ff <= sel.wr_sel;
    end
  end

  wire logic [3:0] rd_rise;
  wire logic [3:0] wr_rise;
  assign rd_rise = sel.rd_sel & ~rd_prev_ff;
  assign wr_rise = sel.wr_sel & ~wr_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte, low nibble undefined so driven zero
  function automatic logic [7:0] status_pack(input logic [3:0] pins);
    logic [7:0] b;
    b = PPD_LOW_NIBBLE;
    b[PPD_BIT_BUSY] = pins[3];
    b[PPD_BIT_PAPER] = pins[2];
    b[PPD_BIT_SELECT] = pins[1];
    b[PPD_BIT_FAULT] = pins[0];
    status_pack = b;
  endfunction

  // Status lags the pins by the two synchroniser clocks
  wire logic stat_rd;
  wire logic [7:0] status_byte;
  wire logic [7:0] nxt_data_out;
  assign stat_rd = sel.rd_sel[2];
  assign status_byte = status_pack(st_sync_ff);
  // Bus reads zero outside a status read, so no stale byte leaks
  assign nxt_data_out = stat_rd ? status_byte : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= nxt_data_out;
      data_oe <= sel.rd_sel[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch and data strobe
  logic [7:0] data_ff;
  logic pend_ff;
  logic [PPD_CNT_W-1:0] cnt_ff;
  logic strobe_n_ff;
  wire logic prn_wr;
  wire logic cnt_live;
  wire logic [PPD_CNT_W-1:0] nxt_cnt;
  wire logic nxt_strobe_n;
  assign prn_wr = wr_rise[2];
  assign cnt_live = cnt_ff > PPD_CNT_W'(1);
  // Width is counted in clocks, so it tracks the clock rate
  // A write inside a pulse restarts the full width; the host must pace writes
  assign nxt_cnt = pend_ff ? PPD_STROBE_LEN : (cnt_live ? cnt_ff - 1'b1 : '0);
  assign nxt_strobe_n = pend_ff ? 1'b0 : (cnt_live ? strobe_n_ff : 1'b1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= PPD_DATA_RST;
    end else if (prn_wr) begin
      data_ff <= s_data;
    end
  end

  // Strobe waits one cycle so the latch is already stable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= 1'b0;
      cnt_ff <= '0;
      strobe_n_ff <= 1'b1;
    end else begin
      pend_ff <= prn_wr;
      cnt_ff <= nxt_cnt;
      strobe_n_ff <= nxt_strobe_n;
    end
  end

  // One flop behind the latch, so data leads the strobe by a clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prn_data <= PPD_DATA_RST;
      prn_strobe_n <= 1'b1;
    end else begin
      prn_data <= data_ff;
      prn_strobe_n <= strobe_n_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Floppy interrupt flag; new request wins over the clear
  wire logic irq_clr;
  wire logic nxt_irq;
  assign irq_clr = rd_rise[0];
  assign nxt_irq = s_irq | (fdc_irq_flag & ~irq_clr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fdc_irq_flag <= 1'b0;
    end else begin
      fdc_irq_flag <= nxt_irq;
    end
  end

  // Selects are levels that stand while the decode holds
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fdc_rd_sel <= 1'b0;
      fdc_wr_sel <= 1'b0;
      motor_sel <= 1'b0;
      cassette_sel <= 1'b0;
    end else begin
      fdc_rd_sel <= sel.rd_sel[3];
      fdc_wr_sel <= sel.wr_sel[3];
      motor_sel <= sel.wr_sel[0];
      cassette_sel <= sel.wr_sel[1];
    end
  end

endmodule // ppd_top

/* File: rtl/ppd_pkg.sv */
package ppd_pkg;

  // Decoded address window and per-register addresses
  localparam logic [15:0] PPD_ADDR_IRQ_MOTOR = 16'h37E0;
  localparam logic [15:0] PPD_ADDR_CASSETTE = 16'h37E4;
  localparam logic [15:0] PPD_ADDR_PRINTER = 16'h37E8;
  localparam logic [15:0] PPD_ADDR_FLOPPY = 16'h37EC;

  // Printer status bit positions on the data bus
  localparam int PPD_BIT_BUSY = 7;
  localparam int PPD_BIT_PAPER = 6;
  localparam int PPD_BIT_SELECT = 5;
  localparam int PPD_BIT_FAULT = 4;

  // Reset values and status low-nibble fill
  localparam logic [7:0] PPD_DATA_RST = 8'h00;
  localparam logic [7:0] PPD_LOW_NIBBLE = 8'h00;
  // Idle bus pins high, interrupt request pin low
  localparam logic [27:0] PPD_SYNC_IDLE = 28'hFFFFFFE;

  // Data strobe timing
  localparam int PPD_CLK_MHZ = 40;
  localparam int PPD_STROBE_NS = 1500;
  localparam int PPD_STROBE_CYC = (PPD_STROBE_NS * PPD_CLK_MHZ) / 1000;
  localparam int PPD_CNT_W = 7;
  localparam logic [PPD_CNT_W-1:0] PPD_STROBE_LEN = PPD_CNT_W'(PPD_STROBE_CYC);

  typedef enum logic [1:0] {
    PPD_ACC_NONE,
    PPD_ACC_READ,
    PPD_ACC_WRITE
  } ppd_acc_t;

endpackage

/* File: rtl/ppd_sel_if.sv */
`timescale 1ns/1ps
interface ppd_sel_if;
  logic [3:0] rd_sel;
  logic [3:0] wr_sel;
  modport dec (output rd_sel, output wr_sel);
  modport top (input rd_sel, input wr_sel);
endinterface

/* File: rtl/ppd_decoder.sv */
`timescale 1ns/1ps
module ppd_decoder
  import ppd_pkg::*;
(
  // Synchronised bus inputs
  input wire logic [15:0] addr,
  input wire logic ras_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Select levels, one-hot per slot
  ppd_sel_if.dec sel
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    hit = (a == base);
  endfunction

  wire logic upper_ok;
  wire logic enable;
  wire logic rd_only;
  wire logic wr_only;
  wire logic [3:0] slot;

  // Row strobe low plus A15/A14/A11 low and upper match
  assign upper_ok = ~addr[15] & ~addr[14] & ~addr[11] & (addr[15:4] == PPD_ADDR_IRQ_MOTOR[15:4]);
  assign enable = upper_ok & ~ras_n;
  assign slot = {hit(addr, PPD_ADDR_FLOPPY), hit(addr, PPD_ADDR_PRINTER),
                 hit(addr, PPD_ADDR_CASSETTE), hit(addr, PPD_ADDR_IRQ_MOTOR)};
  assign rd_only = ~rd_n & wr_n;
  assign wr_only = ~wr_n & rd_n;
  // Cassette read slot left unconnected
  assign sel.rd_sel = (enable & rd_only) ? (slot & 4'hD) : 4'h0;
  assign sel.wr_sel = (enable & wr_only) ? slot : 4'h0;

endmodule // ppd_decoder

/* File: verification/ppd_printer_model.sv */
`timescale 1ns/1ps
module ppd_printer_model #(parameter int BUSY_CYC = 400) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Printer pins
  input wire logic [7:0] prn_data,
  input wire logic prn_strobe_n,
  input wire logic sel_in,
  input wire logic fault_in,
  output logic prn_busy,
  output logic prn_paper_empty,
  output logic prn_selected,
  output logic prn_fault
);
  int cnt_ff;
  logic stb_ff;
  // Byte taken as the strobe ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 0;
      stb_ff <= 1'b1;
    end else begin
      stb_ff <= prn_strobe_n;
      if (prn_strobe_n && !stb_ff && (prn_data == 8'h0A || prn_data == 8'h0D)) cnt_ff <= BUSY_CYC;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
  assign prn_busy = cnt_ff != 0;
  // Wired together, so either bit shows busy
  assign prn_paper_empty = prn_busy;
  assign prn_selected = sel_in;
  assign prn_fault = fault_in;
endmodule // ppd_printer_model

/* File: verification/ppd_top_sva.sv */
`timescale 1ns/1ps
module ppd_top_sva (
  // Watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] addr,
  input wire logic ras_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input logic [7:0] data_out,
  input logic data_oe,
  input logic [7:0] prn_data,
  input logic prn_strobe_n,
  input wire logic fdc_irq,
  input logic fdc_irq_flag,
  input logic fdc_rd_sel,
  input logic fdc_wr_sel,
  input logic motor_sel,
  input logic cassette_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire any_sel = fdc_rd_sel | fdc_wr_sel | motor_sel | cassette_sel | data_oe;
  sequence s_strobe_run;
    ##59 !prn_strobe_n ##1 prn_strobe_n;
  endsequence
  a_strobe_len: assert property ($fell(prn_strobe_n) |-> s_strobe_run)
    else $error("strobe width wrong");
  a_data_steady: assert property (!prn_strobe_n |-> $stable(prn_data))
    else $error("data moved under strobe");
  a_low_nibble: assert property (data_oe |-> data_out[3:0] == 4'h0)
    else $error("status low bits set");
  a_one_select: assert property ($onehot0({fdc_rd_sel, fdc_wr_sel, motor_sel, cassette_sel, data_oe}))
    else $error("two selects at once");
  a_row_gate: assert property (ras_n [*6] |-> !any_sel)
    else $error("select without row strobe");
  a_dual_strobe: assert property ((rd_n == wr_n) [*6] |-> !any_sel)
    else $error("select with both strobes equal");
  a_addr_window: assert property ((addr[15:4] != 12'h37E) [*6] |-> !any_sel)
    else $error("select outside window");
  a_flag_set: assert property (fdc_irq [*5] |-> fdc_irq_flag)
    else $error("interrupt flag not set");
endmodule // ppd_top_sva
bind ppd_top ppd_top_sva u_sva (.clk, .rst_b, .addr, .ras_n, .rd_n, .wr_n, .data_out, .data_oe, .prn_data,
  .prn_strobe_n, .fdc_irq, .fdc_irq_flag, .fdc_rd_sel, .fdc_wr_sel, .motor_sel, .cassette_sel);

/* File: verification/printer_port_io_decoder_tb.sv */
`timescale 1ns/1ps
module printer_port_io_decoder_tb;
  logic clk = 1'b0, rst_b = 1'b0, ras_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, fdc_irq = 1'b0;
  logic sel_in = 1'b0, fault_in = 1'b0, stb_q = 1'b1, any_q = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] data_in = 8'h00, data_out, prn_data;
  logic data_oe, prn_strobe_n, prn_busy, prn_paper_empty, prn_selected, prn_fault;
  logic fdc_irq_flag, fdc_rd_sel, fdc_wr_sel, motor_sel, cassette_sel;
  logic [4:0] sel_v;
  logic [7:0] exp_d[$];
  logic [4:0] exp_s[$];
  logic [4:0] rd_tab[4] = '{5'h00, 5'h00, 5'h01, 5'h10};
  logic [4:0] wr_tab[4] = '{5'h04, 5'h02, 5'h00, 5'h08};
  int err_total = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  ppd_top dut (.clk, .rst_b, .addr, .ras_n, .rd_n, .wr_n, .data_in, .data_out, .data_oe, .prn_data, .prn_strobe_n,
    .prn_busy, .prn_paper_empty, .prn_selected, .prn_fault, .fdc_irq, .fdc_irq_flag, .fdc_rd_sel, .fdc_wr_sel,
    .motor_sel, .cassette_sel);
  ppd_printer_model prn (.clk, .rst_b, .prn_data, .prn_strobe_n, .sel_in, .fault_in, .prn_busy, .prn_paper_empty,
    .prn_selected, .prn_fault);
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (exp_s.size() != 0 || exp_d.size() != 0) begin
      err_total++;
      $display("[ERR] queue expected 0 seen %0d", exp_s.size() + exp_d.size());
    end
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bus held eight cycles, then a gap wider than the strobe
  task automatic acc(input logic [15:0] a, input logic r, input logic w, input logic [4:0] es, input logic [7:0] d,
    input logic rs = 1'b0);
    @(negedge clk);
    sel_in = 1'($urandom);
    fault_in = 1'($urandom);
    addr = a;
    ras_n = rs;
    rd_n = r;
    wr_n = w;
    data_in = d;
    if (es != 5'h00) exp_s.push_back(es);
    // Model pins follow these inputs a delta later, so read the inputs
    if (es == 5'h01) exp_d.push_back({prn_busy, prn_paper_empty, sel_in, fault_in, 4'h0});
    if (!rs && !w && r && a == 16'h37E8) exp_d.push_back(d);
    repeat (8) @(negedge clk);
    ras_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (70) @(negedge clk);
  endtask
  ////////////////////////////////////////
  assign sel_v = {fdc_rd_sel, fdc_wr_sel, motor_sel, cassette_sel, data_oe};
  always @(posedge clk) begin
    if (rst_b && sel_v !== 5'h00 && !any_q) begin
      chk("select", {3'h0, exp_s.pop_front()}, {3'h0, sel_v});
      if (data_oe) chk("status", exp_d.pop_front(), data_out);
    end
    if (stb_q && prn_strobe_n === 1'b0) chk("prn_data", exp_d.pop_front(), prn_data);
    any_q <= sel_v !== 5'h00;
    stb_q <= prn_strobe_n;
  end
  initial begin
    void'($urandom(69));
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(16'h37E0 + 16'(4 * i), 1'b0, 1'b1, rd_tab[i], 8'($urandom));
      acc(16'h37E0 + 16'(4 * i), 1'b1, 1'b0, wr_tab[i], 8'($urandom) | 8'h80);
    end
    for (int i = 0; i < 2; i++) begin
      acc(16'h37E8, 1'b1, 1'b0, 5'h00, i ? 8'h0A : 8'h0D);
      acc(16'h37E8, 1'b0, 1'b1, 5'h01, 8'h00);
      repeat (400) @(negedge clk);
      acc(16'h37E8, 1'b0, 1'b1, 5'h01, 8'h00);
    end
    acc(16'h37EC, 1'b0, 1'b1, 5'h00, 8'h00, 1'b1);
    acc(16'h37EC, 1'b0, 1'b0, 5'h00, 8'h00);
    acc(16'h3FE8, 1'b0, 1'b1, 5'h00, 8'h00);
    acc(16'h37F0, 1'b1, 1'b0, 5'h00, 8'h00);
    fdc_irq = 1'b1;
    repeat (8) @(negedge clk);
    fdc_irq = 1'b0;
    chk("irq_flag", 8'h01, {7'h00, fdc_irq_flag});
    acc(16'h37E0, 1'b0, 1'b1, 5'h00, 8'h00);
    chk("irq_flag", 8'h00, {7'h00, fdc_irq_flag});
    complete_run();
  end
  // Far above the few thousand cycles the sequence needs
  initial begin
    #250000;
    err_total++;
    $display("[ERR] watchdog expected done seen timeout");
    complete_run();
  end
endmodule // printer_port_io_decoder_tb
